/* File: logic/oscillator_control_status.sv */
// oscillator control and status register with axi4-lite access
`timescale 1ns/100ps
`include "osc_ctrl_consts.svh"
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - current source field at bits 14..12 is read-only, writes ignored
// - codes 000 fast rc, 001 fast rc with pll, 010 primary oscillator
// - codes 101 low-power rc, 110 fast rc div 16, 111 fast rc div n
// - software writes requested source at bits 10..8, same encoding
// - source freeze set with config 0b01 blocks starting a source switch, one already under way still completes
// - source freeze clear lets clock switching change the source
// - pin remap freeze set blocks writes to pin select registers
// - pin remap freeze clear lets pin select writes through
// - bit 5 reads the synchronised pll locked input, else zero
// - clock failure flag at bit 3 set by monitor, cleared by software
// - bits 15, 11, 4 and unused positions read zero, ignore writes
module oscillator_control_status
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic pllLocked,
    input wire logic clockFailDetect,
    input wire logic switchDone,
    input wire logic [2:0] configSource,
    input wire logic [1:0] configFcksm,
    input wire logic ppsWriteReq,
    output logic ppsWriteCommit,
    output logic switchRequest,
    output logic [2:0] switchTarget,
    output logic [2:0] currentClockSource
);
    osc_ctrl_pkg::osc_state_t s;
    osc_ctrl_pkg::osc_state_t next_s;
    osc_ctrl_pkg::sync_bus_t rawIn;
    osc_ctrl_pkg::sync_bus_t syn;
    logic failRise;
    logic doWrite;
    logic switchBlocked;

    //////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic addrHit(input logic [11:0] a);
        addrHit = (a & `OSC_WORD_MASK) == `OSC_REG_ADDR;
    endfunction

    // unimplemented positions are tied low here
    function automatic logic [15:0] regWord(
        input osc_ctrl_pkg::osc_state_t st,
        input logic pll
    );
        regWord = {1'b0, st.curSrc, 1'b0, st.reqSrc, st.srcFreeze,
                   st.pinFreeze, pll, 1'b0, st.clkFail, 3'h0};
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // input synchronisation

    assign rawIn.fcksm = configFcksm;
    assign rawIn.source = configSource;
    assign rawIn.switchDone = switchDone;
    assign rawIn.clockFail = clockFailDetect;
    assign rawIn.pllLocked = pllLocked;

    osc_input_sync u_sync
    (
        .clk(clk),
        .rst(rst),
        .din(rawIn),
        .dout(syn)
    );

    //////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        next_s = s;
        // pin select writes pass only while unfrozen
        next_s.ppsCommit = ppsWriteReq && !s.pinFreeze;
        next_s.failPrev = syn.clockFail;
        failRise = syn.clockFail && !s.failPrev;
        switchBlocked = s.srcFreeze && (syn.fcksm == `FCKSM_SWITCH_NO_MON);
        doWrite = s.awHeld && s.wHeld && !s.bValid;

        if (awvalid && s.awReady)
        begin
            next_s.awHeld = 1'b1;
            next_s.awAddr = awaddr;
        end
        if (wvalid && s.wReady)
        begin
            next_s.wHeld = 1'b1;
            next_s.wData = wdata[15:0];
            next_s.wStrb = wstrb[1:0];
        end
        if (s.bValid && bready)
        begin
            next_s.bValid = 1'b0;
        end
        if (doWrite)
        begin
            next_s.awHeld = 1'b0;
            next_s.wHeld = 1'b0;
            next_s.bValid = 1'b1;
            next_s.bResp = addrHit(s.awAddr) ? `RESP_OKAY : `RESP_SLVERR;
            // current source and reserved bits are never written
            if (addrHit(s.awAddr) && s.wStrb[1])
            begin
                next_s.reqSrc = s.wData[`REQ_SRC_LSB +: 3];
            end
            if (addrHit(s.awAddr) && s.wStrb[0])
            begin
                next_s.srcFreeze = s.wData[`SRC_FREEZE_BIT];
                next_s.pinFreeze = s.wData[`PIN_FREEZE_BIT];
                if (!s.wData[`CLK_FAIL_BIT])
                begin
                    next_s.clkFail = 1'b0;
                end
            end
        end
        // a failure seen while software clears still leaves the flag set
        if (failRise)
        begin
            next_s.clkFail = 1'b1;
        end
        next_s.awReady = !next_s.awHeld && !next_s.bValid;
        next_s.wReady = !next_s.wHeld && !next_s.bValid;

        if (s.rValid && rready)
        begin
            next_s.rValid = 1'b0;
        end
        if (arvalid && s.arReady)
        begin
            next_s.rValid = 1'b1;
            next_s.rData = addrHit(araddr) ? {16'h0000, regWord(s, syn.pllLocked)} : 32'h0;
            next_s.rResp = addrHit(araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end
        next_s.arReady = !next_s.rValid;

        case (s.fsm)
            osc_ctrl_pkg::ST_INIT:
            begin
                // straps are read only once they have crossed the synchroniser
                next_s.initCount = s.initCount + 2'h1;
                if (s.initCount == `INIT_CYCLES)
                begin
                    next_s.curSrc = syn.source;
                    next_s.reqSrc = syn.source;
                    next_s.fsm = osc_ctrl_pkg::ST_IDLE;
                end
            end
            osc_ctrl_pkg::ST_IDLE:
            begin
                // encoding of codes is carried through unchanged to the switcher
                if ((s.reqSrc != s.curSrc) && !switchBlocked)
                begin
                    next_s.target = s.reqSrc;
                    next_s.switchReq = 1'b1;
                    next_s.fsm = osc_ctrl_pkg::ST_SWITCH;
                end
            end
            osc_ctrl_pkg::ST_SWITCH:
            begin
                // old source is reported until the switcher confirms
                if (syn.switchDone)
                begin
                    next_s.curSrc = s.target;
                    next_s.switchReq = 1'b0;
                    next_s.fsm = osc_ctrl_pkg::ST_IDLE;
                end
            end
            default:
            begin
                next_s.fsm = osc_ctrl_pkg::ST_INIT;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s <= '0;
            s.curSrc <= `RESET_SRC;
            s.reqSrc <= `RESET_SRC;
            s.fsm <= osc_ctrl_pkg::ST_INIT;
        end
        else
        begin
            s <= next_s;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // outputs

    assign awready = s.awReady;
    assign wready = s.wReady;
    assign bvalid = s.bValid;
    assign bresp = s.bResp;
    assign arready = s.arReady;
    assign rvalid = s.rValid;
    assign rdata = s.rData;
    assign rresp = s.rResp;
    assign ppsWriteCommit = s.ppsCommit;
    assign switchRequest = s.switchReq;
    assign switchTarget = s.target;
    assign currentClockSource = s.curSrc;

    //////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_cur_src_ro;
        !$stable(s.curSrc) |->
            $past(s.fsm == osc_ctrl_pkg::ST_INIT) ||
            ($past(s.fsm == osc_ctrl_pkg::ST_SWITCH) && $past(syn.switchDone));
    endproperty
    a_cur_src_ro: assert property (p_cur_src_ro)
        else $error("current source changed without a completed switch");

    property p_switch_done;
        (s.fsm == osc_ctrl_pkg::ST_SWITCH) && syn.switchDone |=>
            (s.curSrc == $past(s.target)) && !s.switchReq;
    endproperty
    a_switch_done: assert property (p_switch_done)
        else $error("current source not updated on switch completion");

    property p_freeze_holds;
        (s.fsm == osc_ctrl_pkg::ST_IDLE) && s.srcFreeze &&
            (syn.fcksm == `FCKSM_SWITCH_NO_MON) |=> !s.switchReq;
    endproperty
    a_freeze_holds: assert property (p_freeze_holds)
        else $error("switch started while source frozen");

    property p_switch_start;
        (s.fsm == osc_ctrl_pkg::ST_IDLE) && !s.srcFreeze && (s.reqSrc != s.curSrc) |=>
            s.switchReq && (s.target == $past(s.reqSrc));
    endproperty
    a_switch_start: assert property (p_switch_start)
        else $error("unfrozen switch request not started");

    property p_pps_block;
        ppsWriteReq && s.pinFreeze |=> !ppsWriteCommit;
    endproperty
    a_pps_block: assert property (p_pps_block)
        else $error("pin select write passed while frozen");

    property p_pps_pass;
        ppsWriteReq && !s.pinFreeze |=> ppsWriteCommit;
    endproperty
    a_pps_pass: assert property (p_pps_pass)
        else $error("pin select write dropped while unfrozen");

    property p_pll_read;
        arvalid && arready && addrHit(araddr) |=>
            rvalid && (rdata[`PLL_LOCK_BIT] == $past(syn.pllLocked));
    endproperty
    a_pll_read: assert property (p_pll_read)
        else $error("pll status bit read wrong");

    property p_fail_set;
        syn.clockFail && !s.failPrev |=> s.clkFail ##1 (s.clkFail || $past(doWrite));
    endproperty
    a_fail_set: assert property (p_fail_set)
        else $error("clock failure flag not set or lost");

    property p_reserved_zero;
        rvalid |-> (rdata[31:16] == 16'h0000) && !rdata[15] && !rdata[11] &&
            !rdata[4] && (rdata[2:0] == 3'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit read nonzero");

    property p_req_write;
        doWrite && addrHit(s.awAddr) && s.wStrb[1] |=>
            s.reqSrc == $past(s.wData[`REQ_SRC_LSB +: 3]);
    endproperty
    a_req_write: assert property (p_req_write)
        else $error("requested source not stored");

    property p_bresp_timely;
        s.awHeld && s.wHeld && !bvalid |=> bvalid;
    endproperty
    a_bresp_timely: assert property (p_bresp_timely)
        else $error("write response missing");

    c_switch: cover property ((s.fsm == osc_ctrl_pkg::ST_SWITCH) ##[1:50]
        (s.fsm == osc_ctrl_pkg::ST_IDLE));
    c_fail: cover property ($rose(s.clkFail) ##[1:100] $fell(s.clkFail));
    c_read: cover property (rvalid && rready);
    c_pps_block: cover property (ppsWriteReq && s.pinFreeze);
endmodule

/* File: logic/osc_ctrl_consts.svh */
// constants for the oscillator control register block
`ifndef OSC_CTRL_CONSTS_SVH
`define OSC_CTRL_CONSTS_SVH
`define OSC_REG_ADDR 12'h000
`define OSC_WORD_MASK 12'hffc
`define CUR_SRC_LSB 12
`define REQ_SRC_LSB 8
`define SRC_FREEZE_BIT 7
`define PIN_FREEZE_BIT 6
`define PLL_LOCK_BIT 5
`define CLK_FAIL_BIT 3
`define SRC_FAST_RC 3'h0
`define SRC_FAST_RC_PLL 3'h1
`define SRC_PRIMARY 3'h2
`define SRC_LOW_POWER_RC 3'h5
`define SRC_FAST_RC_DIV16 3'h6
`define SRC_FAST_RC_DIVN 3'h7
`define FCKSM_SWITCH_NO_MON 2'h1
`define INIT_CYCLES 2'h3
`define RESET_SRC 3'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: logic/osc_ctrl_pkg.sv */
// types shared by the oscillator control block
package osc_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_INIT = 2'b00,
        ST_IDLE = 2'b01,
        ST_SWITCH = 2'b10
    } switch_state_t;

    // inputs that arrive from the clock sources and straps
    typedef struct packed {
        logic [1:0] fcksm;
        logic [2:0] source;
        logic switchDone;
        logic clockFail;
        logic pllLocked;
    } sync_bus_t;

    typedef struct packed {
        sync_bus_t stage1;
        sync_bus_t stage2;
    } sync_state_t;

    typedef struct packed {
        switch_state_t fsm;
        logic [1:0] initCount;
        logic [2:0] curSrc;
        logic [2:0] reqSrc;
        logic [2:0] target;
        logic srcFreeze;
        logic pinFreeze;
        logic clkFail;
        logic failPrev;
        logic switchReq;
        logic ppsCommit;
        logic awHeld;
        logic wHeld;
        logic [11:0] awAddr;
        logic [15:0] wData;
        logic [1:0] wStrb;
        logic awReady;
        logic wReady;
        logic bValid;
        logic [1:0] bResp;
        logic arReady;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
    } osc_state_t;
endpackage

/* File: logic/osc_input_sync.sv */
// two-stage synchroniser for the oscillator status and strap inputs
`timescale 1ns/100ps
module osc_input_sync
(
    input wire logic clk,
    input wire logic rst,
    input osc_ctrl_pkg::sync_bus_t din,
    output osc_ctrl_pkg::sync_bus_t dout
);
    osc_ctrl_pkg::sync_state_t s;
    osc_ctrl_pkg::sync_state_t next_s;

    // stage1 feeds stage2 only
    always_comb
    begin
        next_s = s;
        next_s.stage1 = din;
        next_s.stage2 = s.stage1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign dout = s.stage2;
endmodule

/* File: test/osc_source_model.sv */
// behavioural clock switcher that answers the block's switch request
`timescale 1ns/100ps
module osc_source_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic switchRequest,
    input wire logic slow,
    output logic switchDone
);
    logic [3:0] delayCnt;
    //////////////////////////////////////////////////////////////////////////////
    // done is held until the request drops, so it always outlasts the three-cycle minimum
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            delayCnt <= 4'h0;
            switchDone <= 1'b0;
        end
        else if (!switchRequest)
        begin
            delayCnt <= 4'h0;
            switchDone <= 1'b0;
        end
        else if (delayCnt == (slow ? 4'hc : 4'h1))
            switchDone <= 1'b1;
        else
            delayCnt <= delayCnt + 4'h1;
    end
endmodule

/* File: test/oscillator_control_status_tb.sv */
// self-checking bench for the oscillator control and status register
`timescale 1ns/100ps
module oscillator_control_status_tb;
    typedef struct packed {
        logic [15:0] wrVal;
        logic [31:0] rdVal;
    } row_t;
    // pll locked, no freeze bits; wrVal also pokes read-only and unused bits
    localparam row_t rows [6] = '{
        '{16'h0100, 32'h0000_1120}, '{16'h0200, 32'h0000_2220}, '{16'h8d10, 32'h0000_5520},
        '{16'h7600, 32'h0000_6620}, '{16'h0700, 32'h0000_7720}, '{16'h0000, 32'h0000_0020}};
    logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, slow;
    logic pllLocked, clockFailDetect, switchDone, ppsWriteReq, ppsWriteCommit, switchRequest;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, configFcksm;
    logic [2:0] configSource, switchTarget, currentClockSource, prev;
    int error_cnt, checks;
    //////////////////////////////////////////////////////////////////////////////
    oscillator_control_status u_oscillator_control_status (.clk(clk), .rst(rst),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .pllLocked(pllLocked),
        .clockFailDetect(clockFailDetect), .switchDone(switchDone),
        .configSource(configSource), .configFcksm(configFcksm), .ppsWriteReq(ppsWriteReq),
        .ppsWriteCommit(ppsWriteCommit), .switchRequest(switchRequest),
        .switchTarget(switchTarget), .currentClockSource(currentClockSource));
    osc_source_model u_osc_source_model (.clk(clk), .rst(rst), .switchRequest(switchRequest),
        .slow(slow), .switchDone(switchDone));
    //////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (error_cnt == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // handshake flags are sampled 1 ns after an edge, where they have settled
    task automatic wr(input logic [11:0] a, input logic [15:0] v, input logic [1:0] er);
        logic aw, w, b;
        logic [1:0] r;
        b = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {16'hffff, v};
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        #1;
        while (!b)
        begin
            aw = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            r = bresp;
            @(posedge clk);
            if (aw)
                awvalid <= 1'b0;
            if (w)
                wvalid <= 1'b0;
            if (b)
                bready <= 1'b0;
            #1;
        end
        chk(32'(r), 32'(er));
    endtask
    task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] q);
        logic t, got;
        logic [1:0] r;
        got = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        #1;
        while (!got)
        begin
            t = arvalid && arready;
            got = rvalid;
            q = rdata;
            r = rresp;
            @(posedge clk);
            if (t)
                arvalid <= 1'b0;
            if (got)
                rready <= 1'b0;
            #1;
        end
        chk(32'(r), 32'(er));
    endtask
    task automatic waitSrc(input logic [2:0] c);
        int n;
        n = 0;
        while (currentClockSource !== c && n < 60)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(32'(currentClockSource), 32'(c));
    endtask
    task automatic ppsPulse(input logic e);
        @(posedge clk);
        ppsWriteReq <= 1'b1;
        @(posedge clk);
        ppsWriteReq <= 1'b0;
        #1;
        chk(32'(ppsWriteCommit), 32'(e));
    endtask
    //////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        #40000;
        error_cnt++;
        close_out();
    end
    initial
    begin
        {rst, awvalid, wvalid, bready, arvalid, rready, slow} = 7'h40;
        {pllLocked, clockFailDetect, ppsWriteReq} = 3'h0;
        {awaddr, araddr, wdata, wstrb} = 60'h0;
        configSource = 3'h0;
        configFcksm = 2'h1;
        error_cnt = 0;
        checks = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        rd(12'h000, 2'h0, d);
        chk(d, 32'h0000_0000);
        @(posedge clk);
        pllLocked <= 1'b1;
        repeat (4) @(posedge clk);
        rd(12'h000, 2'h0, d);
        chk(d, 32'h0000_0020);
        prev = 3'h0;
        for (int i = 0; i < 6; i++)
        begin
            slow <= i[0];
            wr(12'h000, rows[i].wrVal, 2'h0);
            rd(12'h000, 2'h0, d);
            chk(32'(d[14:12]), 32'(prev));
            chk(32'({switchRequest, switchTarget}), 32'({1'b1, rows[i].wrVal[10:8]}));
            waitSrc(rows[i].wrVal[10:8]);
            rd(12'h000, 2'h0, d);
            chk(d, rows[i].rdVal);
            prev = rows[i].wrVal[10:8];
        end
        wr(12'h004, 16'h0300, 2'h2);
        rd(12'h004, 2'h2, d);
        chk(d, 32'h0000_0000);
        // source freeze with the switch-no-monitor setting must hold the old source
        wr(12'h000, 16'h0180, 2'h0);
        repeat (30) @(posedge clk);
        #1;
        chk(32'({switchRequest, currentClockSource}), 32'h0);
        rd(12'h000, 2'h0, d);
        chk(d, 32'h0000_01a0);
        wr(12'h000, 16'h0100, 2'h0);
        waitSrc(3'h1);
        ppsPulse(1'b1);
        wr(12'h000, 16'h0140, 2'h0);
        ppsPulse(1'b0);
        @(posedge clk);
        clockFailDetect <= 1'b1;
        repeat (5) @(posedge clk);
        rd(12'h000, 2'h0, d);
        chk(d, 32'h0000_1168);
        wr(12'h000, 16'h0148, 2'h0);
        rd(12'h000, 2'h0, d);
        chk(d, 32'h0000_1168);
        clockFailDetect <= 1'b0;
        wr(12'h000, 16'h7140, 2'h0);
        rd(12'h000, 2'h0, d);
        chk(d, 32'h0000_1160);
        @(posedge clk);
        pllLocked <= 1'b0;
        repeat (4) @(posedge clk);
        rd(12'h000, 2'h0, d);
        chk(d, 32'h0000_1140);
        // without the monitor-off setting the freeze bit no longer blocks a switch
        configFcksm <= 2'h0;
        wr(12'h000, 16'h0280, 2'h0);
        waitSrc(3'h2);
        // mid-run reset: outputs drop at once, straps are taken again afterwards
        @(posedge clk);
        rst <= 1'b1;
        configSource <= 3'h5;
        @(posedge clk);
        #1;
        chk(32'({switchRequest, currentClockSource, ppsWriteCommit, awready}), 32'h0);
        @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        rd(12'h000, 2'h0, d);
        chk(d, 32'h0000_5500);
        close_out();
    end
endmodule
